// ==== design/sfw_regs.vh ====
// constants for the serial flash erase and wrap control block
`ifndef SFW_REGS_VH
`define SFW_REGS_VH

// opcodes
`define SFW_OP_WRITE_ENABLE_CMD   8'h06
`define SFW_OP_RDSR   8'h05
`define SFW_OP_QREAD  8'heb
`define SFW_OP_WRAP   8'h77
`define SFW_OP_PAGE   8'h81
`define SFW_OP_SECT   8'h20
`define SFW_OP_HBLK   8'h52
`define SFW_OP_BLK    8'hd8
`define SFW_OP_CHIP1  8'h60
`define SFW_OP_CHIP2  8'hc7
`define SFW_OP_CRST   8'hff

// exact frame lengths in serial clocks
`define SFW_LEN_OP    6'h08
`define SFW_LEN_ADR   6'h20
`define SFW_LEN_WRAP  6'h28

// continuation code that keeps the shortcut
`define SFW_CONT_KEEP 2'b10

// status byte bit positions
`define SFW_ST_BUSY   0
`define SFW_ST_WEL    1

// erase kinds
`define SFW_K_PAGE    3'h1
`define SFW_K_SECT    3'h2
`define SFW_K_HBLK    3'h3
`define SFW_K_BLK     3'h4
`define SFW_K_CHIP    3'h5

// reset value of the wrap setting (wrap off)
`define SFW_WRAP_RST  3'h1

// clock rate and erase times in microseconds
`define SFW_CLK_MHZ   100
`define SFW_PE_US     10000
`define SFW_SE_US     50000
`define SFW_HB_US     150000
`define SFW_BE_US     250000
`define SFW_CE_US     5000000

`endif

// ==== design/sfw_ctrl.v ====
// serial flash command control for erase, wrap and quad read shortcut
// What this block does
// - continuation 10 keeps opcode-free quad reads
// - other continuation values leave shortcut mode
// - continuation reset command clears shortcut mode
// - wrap command: opcode, 24 dummy, wrap byte
// - wrapped reads stay in aligned section
// - wrap bit4 off, bits6:5 pick length
// - page erase 81h sets page ones
// - erase runs only with write latch set
// - sector erase picks sector from A12 up
// - chip select off byte boundary rejects erase
// - erase frame: opcode, three address bytes
// - busy during erase, then latch cleared
// - status reads allowed during erase
// - protected sector or block not erased
// - opcode 52 erases 32K block
// - protected 32K block still clears latch
// - opcode D8 erases 64K block
// - chip erase 60 or C7, no address
// - chip erase only with nothing protected
// - quad read: address, mode, 4 dummies, data
// - quad read rejected while busy
`timescale 1ns/10ps
`include "sfw_regs.vh"

module sfw_ctrl #(
   parameter BLK_W = 5, // log2 of 64K blocks
   parameter [31:0] PE_CYC = `SFW_PE_US * `SFW_CLK_MHZ,
   parameter [31:0] SE_CYC = `SFW_SE_US * `SFW_CLK_MHZ,
   parameter [31:0] HB_CYC = `SFW_HB_US * `SFW_CLK_MHZ,
   parameter [31:0] BE_CYC = `SFW_BE_US * `SFW_CLK_MHZ,
   parameter [31:0] CE_CYC = `SFW_CE_US * `SFW_CLK_MHZ
) (
   input  wire        ref_clk,              // system clock
   input  wire        rst,                  // async reset
   input  wire        cs_n_pin,             // chip select pin
   input  wire        sclk_pin,             // serial clock pin
   input  wire [3:0]  io_in,                // io lanes in
   output reg  [3:0]  io_out_q,             // io lanes out
   output reg  [3:0]  io_oe_q,              // io lane enables
   input  wire        quad_lane_enable,     // quad lanes allowed
   input  wire [4:0]  protect_bits,         // protection code
   input  wire [7:0]  rd_data,              // array read byte
   output reg  [23:0] rd_addr_q,            // array read address
   output reg         busy_flag_q,          // erase running
   output reg         write_latch_flag_q,   // write latch
   output reg         cont_mode_q,          // shortcut active
   output reg  [2:0]  wrap_setting_bits_q,  // wrap bits 6:4
   output reg         erase_go_q,           // erase start pulse
   output reg  [2:0]  erase_kind_q,         // erase kind
   output reg  [23:0] erase_addr_q          // aligned erase base
);

   // one-hot frame states
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_CMD  = 9'h002;
   localparam [8:0] ST_ADDR = 9'h004;
   localparam [8:0] ST_QADR = 9'h008;
   localparam [8:0] ST_QMOD = 9'h010;
   localparam [8:0] ST_QDUM = 9'h020;
   localparam [8:0] ST_QDAT = 9'h040;
   localparam [8:0] ST_STAT = 9'h080;
   localparam [8:0] ST_SKIP = 9'h100;

   // pin synchronisers, first stage read only by second
   reg        cs_m_q;     // cs first stage
   reg        cs_s_q;     // cs synced
   reg        cs_d_q;     // cs delayed
   reg        sck_m_q;    // sclk first stage
   reg        sck_s_q;    // sclk synced
   reg        sck_d_q;    // sclk delayed
   reg  [3:0] io_m_q;     // io first stage
   reg  [3:0] io_s_q;     // io synced

   // frame state
   reg  [8:0]  st_q;      // frame state
   reg  [7:0]  op_q;      // latched opcode
   reg  [31:0] sh_q;      // input shifter
   reg  [5:0]  tot_q;     // clocks in frame
   reg  [3:0]  cnt_q;     // phase counter
   reg         nib_q;     // low nibble next
   reg  [31:0] tmr_q;     // erase timer

   // edge events
   wire cs_fall  = cs_d_q & ~cs_s_q;   // frame begins
   wire cs_rise  = ~cs_d_q & cs_s_q;   // frame ends
   wire sck_rise = sck_s_q & ~sck_d_q; // sample edge
   wire sck_fall = ~sck_s_q & sck_d_q; // drive edge

   // byte just completed on lane zero
   wire [7:0] op_nx = {sh_q[6:0], io_s_q[0]};

   // status byte seen by status reads
   wire [7:0] sbyte = {6'h00, write_latch_flag_q, busy_flag_q};

   // protection decode over the erase address
   wire [23:0]      ea   = sh_q[23:0];
   wire [BLK_W-1:0] blk  = ea[16+BLK_W-1:16];
   wire [2:0]       pn   = protect_bits[2:0];
   wire [BLK_W-1:0] ptgt = protect_bits[3] ? blk : ~blk;
   wire [2:0]       pshf = pn - 3'h1;
   wire             pnone = (pn == 3'h0);
   wire             phit = !pnone && ((ptgt >> pshf) == 0);

   // wrap section mask for reads
   wire [1:0] wl = wrap_setting_bits_q[2:1];
   wire [7:0] wmask = {2'b00, &wl, wl[1], |wl, 3'b111};
   wire [23:0] rd_inc = rd_addr_q + 24'h000001;

   // erase decode by opcode
   reg        is_er;   // opcode is an erase
   reg [2:0]  er_kind; // kind code
   reg [31:0] er_cyc;  // cycle count
   reg [23:0] er_msk;  // alignment mask
   reg [5:0]  er_len;  // exact frame length
   always @* begin
      is_er   = 1'b1;
      er_kind = `SFW_K_CHIP;
      er_cyc  = CE_CYC;
      er_msk  = 24'h000000;
      er_len  = `SFW_LEN_ADR;
      case (op_q)
         `SFW_OP_PAGE: begin // page from A23..A8
            er_kind = `SFW_K_PAGE;
            er_cyc  = PE_CYC;
            er_msk  = 24'hffff00;
         end
         `SFW_OP_SECT: begin // sector from A12 up
            er_kind = `SFW_K_SECT;
            er_cyc  = SE_CYC;
            er_msk  = 24'hfff000;
         end
         `SFW_OP_HBLK: begin // 32K block
            er_kind = `SFW_K_HBLK;
            er_cyc  = HB_CYC;
            er_msk  = 24'hff8000;
         end
         `SFW_OP_BLK: begin // 64K block
            er_kind = `SFW_K_BLK;
            er_cyc  = BE_CYC;
            er_msk  = 24'hff0000;
         end
         `SFW_OP_CHIP1, `SFW_OP_CHIP2: begin // no address
            er_len = `SFW_LEN_OP;
         end
         default: begin // not an erase
            is_er = 1'b0;
         end
      endcase
   end

   // two-stage synchronisers and edge delay
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {cs_d_q, cs_s_q, cs_m_q}    <= 3'h7; // idle high
         {sck_d_q, sck_s_q, sck_m_q} <= 3'h0; // idle low
         {io_s_q, io_m_q}            <= 8'h00;
      end else begin
         {cs_d_q, cs_s_q, cs_m_q}    <= {cs_s_q, cs_m_q, cs_n_pin};
         {sck_d_q, sck_s_q, sck_m_q} <= {sck_s_q, sck_m_q, sclk_pin};
         {io_s_q, io_m_q}            <= {io_m_q, io_in};
      end
   end

   // command sequencer, erase timer and output drive
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q                <= ST_IDLE;
         op_q                <= 8'h00;
         sh_q                <= 32'h00000000;
         tot_q               <= 6'h00;
         cnt_q               <= 4'h0;
         nib_q               <= 1'b0;
         tmr_q               <= 32'h00000000;
         io_out_q            <= 4'h0;
         io_oe_q             <= 4'h0;
         rd_addr_q           <= 24'h000000;
         busy_flag_q         <= 1'b0;
         write_latch_flag_q  <= 1'b0;
         cont_mode_q         <= 1'b0;
         wrap_setting_bits_q <= `SFW_WRAP_RST;
         erase_go_q          <= 1'b0;
         erase_kind_q        <= 3'h0;
         erase_addr_q        <= 24'h000000;
      end else begin
         erase_go_q <= 1'b0;
         // self-timed cycle ends: busy low, latch cleared
         if (busy_flag_q) begin
            if (tmr_q == 32'h00000000) begin
               busy_flag_q        <= 1'b0;
               write_latch_flag_q <= 1'b0;
            end else begin
               tmr_q <= tmr_q - 32'h00000001;
            end
         end
         if (cs_fall) begin
            // new frame: shortcut skips the opcode
            tot_q   <= 6'h00;
            cnt_q   <= 4'h0;
            nib_q   <= 1'b0;
            op_q    <= 8'h00;
            io_oe_q <= 4'h0;
            if (cont_mode_q && !busy_flag_q) begin
               st_q <= ST_QADR;
            end else if (cont_mode_q) begin
               st_q <= ST_SKIP;
            end else begin
               st_q <= ST_CMD;
            end
         end else if (cs_rise) begin
            // frame end: commands take effect here
            st_q    <= ST_IDLE;
            io_oe_q <= 4'h0;
            if ((st_q == ST_QADR) || (st_q == ST_QMOD) ||
                (op_q == `SFW_OP_CRST)) begin
               // reset command or cut shortcut frame
               cont_mode_q <= 1'b0;
            end
            if (op_q == `SFW_OP_WRITE_ENABLE_CMD && tot_q == `SFW_LEN_OP &&
                !busy_flag_q) begin
               write_latch_flag_q <= 1'b1;
            end
            if (op_q == `SFW_OP_WRAP && tot_q == `SFW_LEN_WRAP &&
                !busy_flag_q) begin
               wrap_setting_bits_q <= sh_q[6:4];
            end
            // erase needs exact length and latch, else dropped
            if (is_er && tot_q == er_len && !busy_flag_q &&
                write_latch_flag_q) begin
               if (er_kind == `SFW_K_CHIP ? pnone : !phit) begin
                  // start self-timed cycle
                  busy_flag_q  <= 1'b1;
                  tmr_q        <= er_cyc;
                  erase_go_q   <= 1'b1;
                  erase_kind_q <= er_kind;
                  erase_addr_q <= ea & er_msk;
               end else if (er_kind == `SFW_K_HBLK) begin
                  write_latch_flag_q <= 1'b0;
               end
            end
         end else if (!cs_s_q && sck_rise) begin
            // count every clock, saturating
            if (tot_q != 6'h3f) begin
               tot_q <= tot_q + 6'h01;
            end
            case (st_q)
               ST_CMD: begin // opcode on lane zero
                  sh_q  <= {sh_q[30:0], io_s_q[0]};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     op_q  <= op_nx;
                     cnt_q <= 4'h0;
                     if (op_nx == `SFW_OP_RDSR) begin
                        st_q <= ST_STAT;
                     end else if (busy_flag_q) begin
                        st_q <= ST_SKIP;
                     end else if (op_nx == `SFW_OP_QREAD) begin
                        // quad read only with lanes enabled
                        st_q <= quad_lane_enable ? ST_QADR : ST_SKIP;
                     end else if (op_nx == `SFW_OP_PAGE ||
                                  op_nx == `SFW_OP_SECT ||
                                  op_nx == `SFW_OP_HBLK ||
                                  op_nx == `SFW_OP_BLK  ||
                                  op_nx == `SFW_OP_WRAP) begin
                        st_q <= ST_ADDR;
                     end else begin
                        st_q <= ST_SKIP;
                     end
                  end
               end
               ST_ADDR: begin // address or dummies on lane zero
                  sh_q <= {sh_q[30:0], io_s_q[0]};
               end
               ST_QADR: begin // six address nibbles
                  sh_q  <= {sh_q[27:0], io_s_q};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h5) begin
                     rd_addr_q <= {sh_q[19:0], io_s_q};
                     cnt_q     <= 4'h0;
                     st_q      <= ST_QMOD;
                  end
               end
               ST_QMOD: begin // continuation byte
                  sh_q  <= {sh_q[27:0], io_s_q};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h1) begin
                     // bits 5:4 sit in the high nibble
                     cont_mode_q <= (sh_q[1:0] == `SFW_CONT_KEEP);
                     cnt_q       <= 4'h0;
                     st_q        <= ST_QDUM;
                  end
               end
               ST_QDUM: begin // four dummy clocks
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == 4'h3) begin
                     st_q <= ST_QDAT;
                  end
               end
               default: begin // data out or ignored frame
                  st_q <= st_q;
               end
            endcase
         end else if (!cs_s_q && sck_fall) begin
            case (st_q)
               ST_STAT: begin // status byte, msb first, repeats
                  io_oe_q  <= 4'h2;
                  io_out_q <= {2'b00, sbyte[~cnt_q[2:0]], 1'b0};
                  cnt_q    <= cnt_q + 4'h1;
               end
               ST_QDAT: begin // high nibble then low nibble
                  io_oe_q  <= 4'hf;
                  io_out_q <= nib_q ? rd_data[3:0] : rd_data[7:4];
                  nib_q    <= ~nib_q;
                  if (nib_q) begin
                     if (!wrap_setting_bits_q[0]) begin
                        // stay inside the aligned section
                        rd_addr_q <= {rd_addr_q[23:8],
                                      (rd_addr_q[7:0] & ~wmask) |
                                      (rd_inc[7:0] & wmask)};
                     end else begin
                        rd_addr_q <= rd_inc;
                     end
                  end
               end
               default: begin // nothing to drive
                  io_oe_q <= 4'h0;
               end
            endcase
         end
      end
   end

endmodule // sfw_ctrl

// ==== test/sfw_ctrl_assertions.sv ====
// concurrent checks on the erase and wrap control ports
`timescale 1ns/10ps
module sfw_ctrl_assertions #(
   parameter [31:0] PE_CYC = 32'h14, // page erase count
   parameter [31:0] SE_CYC = 32'h14, // sector erase count
   parameter [31:0] HB_CYC = 32'h14, // 32K erase count
   parameter [31:0] BE_CYC = 32'h14, // 64K erase count
   parameter [31:0] CE_CYC = 32'h14  // chip erase count
) (
   input wire        ref_clk,             // system clock
   input wire        rst,                 // async reset
   input wire        cs_n_pin,            // chip select
   input wire [3:0]  io_oe_q,             // lane enables
   input wire [4:0]  protect_bits,        // protection code
   input wire        busy_flag_q,         // erase running
   input wire        write_latch_flag_q,  // write latch
   input wire        cont_mode_q,         // shortcut active
   input wire [2:0]  wrap_setting_bits_q, // wrap bits
   input wire        erase_go_q,          // start pulse
   input wire [2:0]  erase_kind_q,        // erase kind
   input wire [23:0] erase_addr_q         // erase base
);
   reg  [31:0] bcnt_q; // cycles busy so far
   // expected busy length by kind
   wire [31:0] need_w = (erase_kind_q == 3'h1) ? PE_CYC :
                        (erase_kind_q == 3'h2) ? SE_CYC :
                        (erase_kind_q == 3'h3) ? HB_CYC :
                        (erase_kind_q == 3'h4) ? BE_CYC : CE_CYC;
   // count busy cycles, cleared when idle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) bcnt_q <= 32'h0;
      else bcnt_q <= busy_flag_q ? bcnt_q + 32'h1 : 32'h0;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_go_one_cycle: assert property (erase_go_q |=> !erase_go_q)
      else $error("erase start pulse longer than one cycle");
   a_go_sets_busy: assert property (erase_go_q |-> ##[0:1] busy_flag_q)
      else $error("busy not raised at erase start");
   a_go_needs_latch: assert property (erase_go_q |-> write_latch_flag_q)
      else $error("erase started without write latch");
   a_go_when_idle: assert property (erase_go_q |-> !$past(busy_flag_q))
      else $error("erase started while busy");
   a_end_clears_latch: assert property ($fell(busy_flag_q) |->
      !write_latch_flag_q) else $error("latch kept after erase");
   a_busy_length: assert property ($fell(busy_flag_q) |->
      bcnt_q == need_w + 32'h1) else $error("busy length wrong");
   a_sect_align: assert property (erase_go_q && erase_kind_q == 3'h2 |->
      erase_addr_q[11:0] == 12'h0) else $error("sector base misaligned");
   a_blk_align: assert property (erase_go_q |->
      (erase_kind_q != 3'h3 || erase_addr_q[14:0] == 15'h0) &&
      (erase_kind_q != 3'h4 || erase_addr_q[15:0] == 16'h0))
      else $error("block base misaligned");
   a_chip_free: assert property (erase_go_q && erase_kind_q == 3'h5 |->
      protect_bits[2:0] == 3'h0 && erase_addr_q == 24'h0)
      else $error("chip erase while protected");
   a_wrap_at_cs: assert property (!$stable(wrap_setting_bits_q) |->
      cs_n_pin) else $error("wrap changed inside a frame");
   a_lanes_idle: assert property (cs_n_pin [*6] |-> io_oe_q == 4'h0)
      else $error("lanes driven while deselected");
   c_erase: cover property (erase_go_q);
   c_cont: cover property ($rose(cont_mode_q));
   c_wrap: cover property (!$stable(wrap_setting_bits_q));
endmodule // sfw_ctrl_assertions

bind sfw_ctrl sfw_ctrl_assertions #(.PE_CYC(PE_CYC), .SE_CYC(SE_CYC),
   .HB_CYC(HB_CYC), .BE_CYC(BE_CYC), .CE_CYC(CE_CYC))
   sfw_ctrl_assertions_inst (.ref_clk(ref_clk), .rst(rst),
   .cs_n_pin(cs_n_pin), .io_oe_q(io_oe_q), .protect_bits(protect_bits),
   .busy_flag_q(busy_flag_q), .write_latch_flag_q(write_latch_flag_q),
   .cont_mode_q(cont_mode_q), .wrap_setting_bits_q(wrap_setting_bits_q),
   .erase_go_q(erase_go_q), .erase_kind_q(erase_kind_q),
   .erase_addr_q(erase_addr_q));

// ==== test/sfw_host.sv ====
// host controller model that drives the serial link
`timescale 1ns/10ps
module sfw_host (
   output logic       cs_n,  // chip select
   output logic       sclk,  // link clock, still between frames
   output logic [3:0] io,    // lanes from host
   input  wire  [3:0] dev_io // resolved lanes
);
   // idle link at start
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io = 4'h0;
   end
   // one link clock, data set while low
   task automatic tick(input logic [3:0] v);
      io = v;
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
   endtask
   // lane0 msb first, upper lanes toggled as noise
   task automatic send(input logic [39:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) tick({~v[i], v[i], ~v[i], v[i]});
   endtask
   task automatic open;
      #62.5 cs_n = 1'b0;
   endtask
   // released lanes show the inverse of the last value
   task automatic close;
      #62.5 cs_n = 1'b1;
      io = ~io;
      #250;
   endtask
   // whole frame, chip select rises after the last bit
   task automatic frame(input logic [39:0] v, input int n);
      open;
      send(v, n);
      close;
   endtask
   // status read, bit taken at each rising edge
   task automatic status(output logic [7:0] s);
      open;
      send(40'h05, 8);
      for (int i = 0; i < 8; i++) begin
         io = ~io;
         #62.5 sclk = 1'b1;
         s = {s[6:0], dev_io[1]};
         #62.5 sclk = 1'b0;
      end
      close;
   endtask
   // quad read with or without opcode, one data byte back
   task automatic quad(input logic [23:0] a, input logic [7:0] m,
                       input bit op, output logic [7:0] d);
      open;
      if (op) send(40'heb, 8);
      for (int i = 5; i >= 0; i--) tick(a[i*4 +: 4]);
      tick(m[7:4]);
      tick(m[3:0]);
      repeat (4) tick(~io);
      // data nibbles taken at each rising edge, high first
      for (int j = 0; j < 2; j++) begin
         io = ~io;
         #62.5 sclk = 1'b1;
         d = {d[3:0], dev_io};
         #62.5 sclk = 1'b0;
      end
      close;
   endtask
endmodule // sfw_host

// ==== test/testbench.sv ====
// self-checking bench for the erase and wrap control block
`timescale 1ns/10ps
module testbench;
   logic        ref_clk;    // system clock
   logic        rst;        // reset
   logic        quad_en;    // quad lanes allowed
   logic [4:0]  prot;       // protection code
   wire         cs_n;       // chip select
   wire         sclk;       // link clock
   wire  [3:0]  hio;        // host lanes
   wire  [3:0]  dio;        // device lanes
   wire  [3:0]  oe;         // device enables
   wire  [3:0]  lane;       // resolved lanes
   wire  [23:0] ra;         // read address
   wire         busy;       // busy flag
   wire         lat;        // write latch
   wire         cont;       // shortcut mode
   wire  [2:0]  wrap;       // wrap bits
   wire         go;         // erase start
   wire  [2:0]  kind;       // erase kind
   wire  [23:0] ea;         // erase base
   int          num_errors = 0; // mismatches
   int          tests_run = 0;  // comparisons
   int          gcnt = 0;   // erase starts seen
   logic [26:0] glast;      // last kind and base
   logic [7:0]  st;         // status byte
   logic [7:0]  qd;         // quad read byte
   wire  [7:0]  rdat;       // array byte model
   // erase rows: opcode and address, then kind and base
   logic [31:0] cmd_t [6] = '{32'h81123456, 32'h20123456, 32'h52123456,
                             32'hd8123456, 32'h60000000, 32'hc7000000};
   logic [26:0] exp_t [6] = '{{3'h1, 24'h123400}, {3'h2, 24'h123000},
      {3'h3, 24'h120000}, {3'h4, 24'h120000}, {3'h5, 24'h0}, {3'h5, 24'h0}};
   assign lane = (oe & dio) | (~oe & hio);
   // array model: each byte holds its own low address bits
   assign rdat = ra[7:0];
   sfw_ctrl #(.PE_CYC(32'h14), .SE_CYC(32'h258), .HB_CYC(32'h14),
      .BE_CYC(32'h14), .CE_CYC(32'h14)) sfw_ctrl_inst (
      .ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .io_in(lane), .io_out_q(dio), .io_oe_q(oe), .quad_lane_enable(quad_en),
      .protect_bits(prot), .rd_data(rdat), .rd_addr_q(ra),
      .busy_flag_q(busy), .write_latch_flag_q(lat), .cont_mode_q(cont),
      .wrap_setting_bits_q(wrap), .erase_go_q(go), .erase_kind_q(kind),
      .erase_addr_q(ea));
   sfw_host sfw_host_inst (.cs_n(cs_n), .sclk(sclk), .io(hio), .dev_io(lane));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // record each erase start
   always @(posedge ref_clk) begin
      if (go === 1'b1) begin
         gcnt++;
         glast = {kind, ea};
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // bounded wait for the erase cycle to end
   task automatic wait_idle;
      int k;
      for (k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge ref_clk);
      if (k == 2000) begin
         num_errors++;
         final_report;
      end
   endtask
   initial begin
      int g;
      int n;
      rst = 1'b1;
      quad_en = 1'b0;
      prot = 5'h0;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(wrap, 3'h1);
      chk({busy, lat, cont}, 3'h0);
      for (int r = 0; r < 6; r++) begin
         g = gcnt;
         sfw_host_inst.frame(40'h06, 8);
         n = (cmd_t[r][23:0] == 24'h0) ? 8 : 32;
         sfw_host_inst.frame(n == 8 ? cmd_t[r] >> 24 : cmd_t[r], n);
         chk(gcnt - g, 1);
         chk(glast, exp_t[r]);
         if (r == 1) begin
            sfw_host_inst.status(st);
            chk(st, 8'h03);
         end
         wait_idle;
         chk(lat, 1'b0);
         $display("erase row %0d done", r);
      end
      g = gcnt;
      sfw_host_inst.frame({8'h20, 24'h001000}, 32);
      chk(gcnt - g, 0);
      sfw_host_inst.frame(40'h06, 8);
      sfw_host_inst.frame({8'h20, 23'h000800}, 31);
      chk(gcnt - g, 0);
      chk(lat, 1'b1);
      @(negedge ref_clk) prot = 5'h06;
      sfw_host_inst.frame({8'h20, 24'h001000}, 32);
      chk(lat, 1'b1);
      sfw_host_inst.frame(40'h60, 8);
      sfw_host_inst.frame({8'h52, 24'h001000}, 32);
      chk(gcnt - g, 0);
      chk(lat, 1'b0);
      @(negedge ref_clk) prot = 5'h0;
      $display("refusal tests done");
      for (int w = 0; w < 4; w++) begin
         sfw_host_inst.frame({8'h77, 24'h0, 1'b0, 2'(w), 5'h0}, 40);
         chk(wrap, {2'(w), 1'b0});
      end
      sfw_host_inst.frame({8'h77, 24'h0, 8'h10}, 40);
      chk(wrap, 3'h1);
      $display("wrap tests done");
      @(negedge ref_clk) quad_en = 1'b1;
      sfw_host_inst.quad(24'h012345, 8'h20, 1'b1, qd);
      chk(cont, 1'b1);
      chk(ra, 24'h012346);
      chk(qd, 8'h45);
      sfw_host_inst.quad(24'h000040, 8'h00, 1'b0, qd);
      chk(cont, 1'b0);
      chk(qd, 8'h40);
      chk(ra, 24'h000041);
      sfw_host_inst.quad(24'h000040, 8'h20, 1'b1, qd);
      chk(cont, 1'b1);
      sfw_host_inst.frame(40'hff, 8);
      chk(cont, 1'b0);
      sfw_host_inst.frame({8'h77, 24'h0, 8'h00}, 40);
      sfw_host_inst.quad(24'h000047, 8'h00, 1'b1, qd);
      chk(qd, 8'h47);
      chk(ra, 24'h000040);
      sfw_host_inst.frame({8'h77, 24'h0, 8'h10}, 40);
      chk(wrap, 3'h1);
      sfw_host_inst.frame(40'h06, 8);
      sfw_host_inst.frame({8'h20, 24'h002000}, 32);
      sfw_host_inst.quad(24'h0, 8'h20, 1'b1, qd);
      chk(cont, 1'b0);
      wait_idle;
      $display("quad tests done");
      final_report;
   end
endmodule // testbench
